// ---- common/kwu_defs.svh ----
// Register offsets, field positions, reset values and timing counts
`ifndef KWU_DEFS_SVH
`define KWU_DEFS_SVH

// Register indexes, byte address is four times the index
`define KWU_IDX_ENABLE   8'h31
`define KWU_IDX_CONTROL  8'h32
`define KWU_IDX_STATUS   8'h33
`define KWU_ADDR_W       10

// Enable register fields
`define KWU_EN_LSB       4
`define KWU_EN_MSB       7
`define KWU_EN_RESET     4'h0

// Control register fields
`define KWU_CTL_STOP     0
`define KWU_CTL_RELEASE_METHOD_SEL     1
`define KWU_RELEASE_METHOD_SEL_RESET   1'h0

// Status register fields
`define KWU_ST_STATE_LSB 0
`define KWU_ST_KEY_LSB   4
`define KWU_ST_PIN       8

// Timing: instruction cycle length and ignore window
`define KWU_CLK_PER_INSTR 4
`define KWU_IGNORE_INSTR  3
`define KWU_WARMUP_CLKS   16
`define KWU_CNT_W         12

// Bus responses
`define KWU_RESP_OKAY    2'h0
`define KWU_RESP_SLVERR  2'h2

`endif

// ---- common/kwu_pkg.sv ----
// Types shared by the key wakeup design
package kwu_pkg;
  typedef enum logic [1:0] {
    ST_RUN    = 2'b00,
    ST_IGNORE = 2'b01,
    ST_STOP   = 2'b10,
    ST_WARMUP = 2'b11
  } pwr_state_e;
endpackage

// ---- rtl/pin_sync.sv ----
// Two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/10ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic             i_ce,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_d;

  // Next values, frozen while enable is low
  always_comb begin
    meta_d = i_ce ? i_async : meta_q;
    sync_d = i_ce ? meta_q : sync_q;
  end

  // First stage feeds only the second
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign o_sync = sync_q;
endmodule // pin_sync

// ---- rtl/key_wakeup.sv ----
// Key wakeup STOP release logic with AXI4-Lite register slave
// Functional notes
// - Four port 3 pins, bits 4 to 7, can release STOP besides the exit pin.
// - Enable bits 7 down to 4 enable each wake pin, 1 enables, 0 disables.
// - The enable register is write-only, upper bits reset to zero.
// - In STOP, a rising or falling edge on an enabled wake pin releases.
// - Release is the OR of the exit pin input and the enabled wake pins.
// - Exit pin releases on high in level mode, on rising edge in edge mode.
// - Release is ignored for three instruction cycles after STOP entry.
// - STOP is entered by the control register; pins watched only in STOP.
// - After release the warm-up period runs before execution resumes.
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/10ps
`include "kwu_defs.svh"
module key_wakeup #(
  parameter int CLK_PER_INSTR = `KWU_CLK_PER_INSTR,
  parameter int IGNORE_INSTR  = `KWU_IGNORE_INSTR,
  parameter int WARMUP_CLKS   = `KWU_WARMUP_CLKS
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_ce,
  input  wire logic [3:0]  i_key_wake,
  input  wire logic        i_stop_pin,
  input  wire logic [31:0] i_awaddr,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  input  wire logic [31:0] i_araddr,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  output logic             o_stop_active,
  output logic             o_warmup_busy,
  output logic             o_release
);
  localparam logic [`KWU_CNT_W-1:0] IGNORE_CNT =
    `KWU_CNT_W'(IGNORE_INSTR * CLK_PER_INSTR - 1);
  localparam logic [`KWU_CNT_W-1:0] WARMUP_CNT =
    `KWU_CNT_W'(WARMUP_CLKS - 1);

  // Synchronised pins: four wake keys and the exit pin
  logic [4:0] pins_s;
  logic [3:0] key_s;
  logic       stop_s;

  pin_sync #(.WIDTH(5)) u_sync (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_ce    (i_ce),
    .i_async ({i_stop_pin, i_key_wake}),
    .o_sync  (pins_s)
  );
  assign key_s  = pins_s[3:0];
  assign stop_s = pins_s[4];

  // Bus state
  logic        aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic [31:0] awaddr_q, awaddr_d, wdata_q, wdata_d;
  logic [3:0]  wstrb_q, wstrb_d;
  logic        awrdy_q, awrdy_d, wrdy_q, wrdy_d;
  logic        bvalid_q, bvalid_d, arrdy_q, arrdy_d, rvalid_q, rvalid_d;
  logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic        do_write, en_wr, ctl_wr, stop_cmd;
  logic [`KWU_ADDR_W-1:0] widx, ridx;
  // Register state
  logic [3:0]  en_q, en_d;
  logic        release_method_sel_q, release_method_sel_d;
  // Power state
  kwu_pkg::pwr_state_e   state_q, state_d;
  logic [`KWU_CNT_W-1:0] cnt_q, cnt_d;
  logic [3:0]            cap_q, cap_d;
  logic                  prev_q, prev_d, rel_q, rel_d;
  logic                  key_hit, pin_hit, cause;

  // Write channel acceptance and register update
  always_comb begin
    aw_have_d = aw_have_q;
    awaddr_d  = awaddr_q;
    w_have_d  = w_have_q;
    wdata_d   = wdata_q;
    wstrb_d   = wstrb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    en_d      = en_q;
    release_method_sel_d    = release_method_sel_q;
    en_wr     = 1'b0;
    ctl_wr    = 1'b0;
    if (bvalid_q && i_bready) begin
      bvalid_d = 1'b0;
    end
    if (i_awvalid && awrdy_q) begin
      aw_have_d = 1'b1;
      awaddr_d  = i_awaddr;
    end
    if (i_wvalid && wrdy_q) begin
      w_have_d = 1'b1;
      wdata_d  = i_wdata;
      wstrb_d  = i_wstrb;
    end
    widx     = awaddr_d[`KWU_ADDR_W+1:2];
    do_write = aw_have_d && w_have_d && !bvalid_d;
    if (do_write) begin
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = `KWU_RESP_OKAY;
      case (widx)
        `KWU_ADDR_W'(`KWU_IDX_ENABLE): en_wr = wstrb_d[0];
        `KWU_ADDR_W'(`KWU_IDX_CONTROL): ctl_wr = wstrb_d[0];
        `KWU_ADDR_W'(`KWU_IDX_STATUS): bresp_d = `KWU_RESP_OKAY;
        default: bresp_d = `KWU_RESP_SLVERR;
      endcase
    end
    if (en_wr) begin
      en_d = wdata_d[`KWU_EN_MSB:`KWU_EN_LSB];
    end
    if (ctl_wr) begin
      release_method_sel_d = wdata_d[`KWU_CTL_RELEASE_METHOD_SEL];
    end
    awrdy_d = !aw_have_d && !bvalid_d;
    wrdy_d  = !w_have_d && !bvalid_d;
  end
  assign stop_cmd = ctl_wr && wdata_d[`KWU_CTL_STOP];

  // Read channel; enable register is write-only and reads zero
  always_comb begin
    rvalid_d = rvalid_q;
    rdata_d  = rdata_q;
    rresp_d  = rresp_q;
    ridx     = i_araddr[`KWU_ADDR_W+1:2];
    if (rvalid_q && i_rready) begin
      rvalid_d = 1'b0;
    end
    if (i_arvalid && arrdy_q) begin
      rvalid_d = 1'b1;
      rresp_d  = `KWU_RESP_OKAY;
      rdata_d  = 32'h0;
      case (ridx)
        `KWU_ADDR_W'(`KWU_IDX_ENABLE): rdata_d = 32'h0;
        `KWU_ADDR_W'(`KWU_IDX_CONTROL): rdata_d[`KWU_CTL_RELEASE_METHOD_SEL] = release_method_sel_q;
        `KWU_ADDR_W'(`KWU_IDX_STATUS): begin
          rdata_d[`KWU_ST_STATE_LSB +: 2] = state_q;
          rdata_d[`KWU_ST_KEY_LSB +: 4]   = key_s;
          rdata_d[`KWU_ST_PIN]            = stop_s;
        end
        default: rresp_d = `KWU_RESP_SLVERR;
      endcase
    end
    arrdy_d = !rvalid_d;
  end

  // Release detection
  always_comb begin
    key_hit = |(en_q & (key_s ^ cap_q));
    pin_hit = release_method_sel_q ? stop_s : (stop_s && !prev_q);
    // OR of exit pin and keys
    cause   = key_hit || pin_hit;
  end

  // Power state sequencing
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    cap_d   = cap_q;
    rel_d   = 1'b0;
    prev_d  = stop_s;
    case (state_q)
      kwu_pkg::ST_RUN: begin
        if (stop_cmd) begin
          state_d = kwu_pkg::ST_IGNORE;
          cnt_d   = IGNORE_CNT;
          cap_d   = key_s;
        end
      end
      kwu_pkg::ST_IGNORE: begin
        if (cnt_q == '0) begin
          state_d = kwu_pkg::ST_STOP;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      kwu_pkg::ST_STOP: begin
        if (cause) begin
          state_d = kwu_pkg::ST_WARMUP;
          cnt_d   = WARMUP_CNT;
          rel_d   = 1'b1;
        end
      end
      kwu_pkg::ST_WARMUP: begin
        if (cnt_q == '0) begin
          state_d = kwu_pkg::ST_RUN;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      default: state_d = kwu_pkg::ST_RUN;
    endcase
  end

  // All state registers, frozen while clock enable is low
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awaddr_q  <= 32'h0;
      wdata_q   <= 32'h0;
      wstrb_q   <= 4'h0;
      awrdy_q   <= 1'b0;
      wrdy_q    <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `KWU_RESP_OKAY;
      arrdy_q   <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0;
      rresp_q   <= `KWU_RESP_OKAY;
      en_q      <= `KWU_EN_RESET;
      release_method_sel_q    <= `KWU_RELEASE_METHOD_SEL_RESET;
      state_q   <= kwu_pkg::ST_RUN;
      cnt_q     <= '0;
      cap_q     <= 4'h0;
      prev_q    <= 1'b0;
      rel_q     <= 1'b0;
    end else if (i_ce) begin
      aw_have_q <= aw_have_d;
      w_have_q  <= w_have_d;
      awaddr_q  <= awaddr_d;
      wdata_q   <= wdata_d;
      wstrb_q   <= wstrb_d;
      awrdy_q   <= awrdy_d;
      wrdy_q    <= wrdy_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      arrdy_q   <= arrdy_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
      en_q      <= en_d;
      release_method_sel_q    <= release_method_sel_d;
      state_q   <= state_d;
      cnt_q     <= cnt_d;
      cap_q     <= cap_d;
      prev_q    <= prev_d;
      rel_q     <= rel_d;
    end
  end

  // Bus and release outputs straight from flops, stop and warm-up flags decoded from state_q
  assign o_awready     = awrdy_q;
  assign o_wready      = wrdy_q;
  assign o_bvalid      = bvalid_q;
  assign o_bresp       = bresp_q;
  assign o_arready     = arrdy_q;
  assign o_rvalid      = rvalid_q;
  assign o_rdata       = rdata_q;
  assign o_rresp       = rresp_q;
  assign o_release     = rel_q;
  assign o_stop_active = (state_q == kwu_pkg::ST_STOP) ||
                         (state_q == kwu_pkg::ST_IGNORE);
  assign o_warmup_busy = (state_q == kwu_pkg::ST_WARMUP);

  // Checks
  ignore_mask_a: assert property (@(posedge i_clk) disable iff (i_rst)
    state_q == kwu_pkg::ST_IGNORE |=> !o_release)
    else $error("release during ignore window");
  ignore_len_a: assert property (@(posedge i_clk) disable iff (i_rst)
    $rose(state_q == kwu_pkg::ST_IGNORE) |-> cnt_q == IGNORE_CNT)
    else $error("ignore window length wrong");
  release_take_a: assert property (@(posedge i_clk) disable iff (i_rst)
    state_q == kwu_pkg::ST_STOP && cause && i_ce
    |=> state_q == kwu_pkg::ST_WARMUP && o_release)
    else $error("enabled cause did not release");
  no_cause_a: assert property (@(posedge i_clk) disable iff (i_rst)
    state_q == kwu_pkg::ST_STOP && !key_hit && !pin_hit
    |=> state_q == kwu_pkg::ST_STOP)
    else $error("release without cause");
  stop_only_a: assert property (@(posedge i_clk) disable iff (i_rst)
    o_release |-> $past(state_q) == kwu_pkg::ST_STOP)
    else $error("release outside STOP");
  warmup_done_a: assert property (@(posedge i_clk) disable iff (i_rst)
    state_q == kwu_pkg::ST_RUN && $past(state_q) == kwu_pkg::ST_WARMUP
    |-> $past(cnt_q) == '0)
    else $error("warm-up cut short");
  enable_reset_a: assert property (@(posedge i_clk)
    $past(i_rst) |-> en_q == `KWU_EN_RESET)
    else $error("enable bits not cleared by reset");
  enable_write_a: assert property (@(posedge i_clk) disable iff (i_rst)
    en_wr && i_ce |=> en_q == $past(wdata_d[`KWU_EN_MSB:`KWU_EN_LSB]))
    else $error("enable write lost");
  edge_mode_a: assert property (@(posedge i_clk) disable iff (i_rst)
    state_q == kwu_pkg::ST_STOP && !release_method_sel_q && prev_q && !key_hit
    |-> !cause)
    else $error("steady exit pin released in edge mode");
  capture_a: assert property (@(posedge i_clk) disable iff (i_rst)
    $rose(state_q == kwu_pkg::ST_IGNORE) |-> cap_q == $past(key_s))
    else $error("entry levels not captured");
  key_rel_c: cover property (@(posedge i_clk)
    state_q == kwu_pkg::ST_STOP && key_hit ##1 o_release);
  pin_rel_c: cover property (@(posedge i_clk)
    state_q == kwu_pkg::ST_STOP && pin_hit && !key_hit ##1 o_release);
  resume_c: cover property (@(posedge i_clk)
    state_q == kwu_pkg::ST_WARMUP ##1 state_q == kwu_pkg::ST_RUN);
endmodule // key_wakeup

// ---- testbench/key_pins.sv ----
// Model of the external keys and exit pin on the wake inputs
`timescale 1ns/10ps
module key_pins (
  input  wire logic       i_clk,
  input  wire logic       i_load,
  input  wire logic [3:0] i_init,
  input  wire logic [3:0] i_flip,
  input  wire logic       i_exit,
  output logic      [3:0] o_key_wake,
  output logic            o_stop_pin
);
  logic [3:0] key_q;
  logic [3:0] key_d;

  // steady key levels
  // Keys hold their level and change only on a load or a flip request
  always_comb begin
    key_d = i_load ? i_init : key_q ^ i_flip;
  end

  // Key level storage
  always_ff @(posedge i_clk) begin
    key_q <= key_d;
  end

  assign o_key_wake = key_q;
  // exit pin low
  // Exit pin stays low unless a scenario raises it
  assign o_stop_pin = i_exit;
endmodule // key_pins

// ---- testbench/key_wakeup_tb.sv ----
// Self-checking bench for the key wakeup STOP release block
`timescale 1ns/10ps
`include "kwu_defs.svh"
module key_wakeup_tb;
  localparam int          wu   = 16;
  localparam logic [31:0] en_a = 32'(`KWU_IDX_ENABLE) << 2;
  localparam logic [31:0] ct_a = 32'(`KWU_IDX_CONTROL) << 2;
  localparam logic [31:0] st_a = 32'(`KWU_IDX_STATUS) << 2;
  localparam logic [33:0] rel_n = {2'h3, 32'hffffffff};
  localparam logic [1:0]  ok   = `KWU_RESP_OKAY;
  localparam logic [1:0]  er   = `KWU_RESP_SLVERR;

  logic        clk;
  logic        rst = 1'b1;
  logic        ce  = 1'b1;
  logic        load = 1'b1;
  logic        ex  = 1'b0;
  logic        aw = 1'b0, w = 1'b0, b = 1'b0, ar = 1'b0, r = 1'b0;
  logic [31:0] awa = 32'h0, wd = 32'h0, ara = 32'h0, m;
  logic [3:0]  stb = 4'hf;
  logic [3:0]  flip = 4'h0, init = 4'h0, keys;
  logic        awr, wr_, bv, arr, rv, sa, wb, rel, sp;
  logic [1:0]  br, rr;
  logic [31:0] rd;
  logic [3:0]  kw;
  logic [33:0] q[$];
  int          failures = 0;
  int          cmp_count = 0;
  int          n;

  // Clock at 200 MHz
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  key_pins pins (.i_clk(clk), .i_load(load), .i_init(init), .i_flip(flip),
    .i_exit(ex), .o_key_wake(kw), .o_stop_pin(sp));

  key_wakeup #(.WARMUP_CLKS(wu)) DUT (.i_clk(clk), .i_rst(rst), .i_ce(ce),
    .i_key_wake(kw), .i_stop_pin(sp), .i_awaddr(awa), .i_awvalid(aw),
    .o_awready(awr), .i_wdata(wd), .i_wstrb(stb), .i_wvalid(w),
    .o_wready(wr_), .o_bresp(br), .o_bvalid(bv), .i_bready(b),
    .i_araddr(ara), .i_arvalid(ar), .o_arready(arr), .o_rdata(rd),
    .o_rresp(rr), .o_rvalid(rv), .i_rready(r), .o_stop_active(sa),
    .o_warmup_busy(wb), .o_release(rel));

  task check(input logic [33:0] g, input logic [33:0] e);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask

  task results();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  function logic [33:0] pop();
    if (q.size() == 0) return 34'h1;
    return q.pop_front();
  endfunction

  // Write cycle, expected response noted first
  task wreq(input logic [31:0] a, input logic [31:0] d, input logic [1:0] e);
    q.push_back({e, 32'h0});
    awa <= a;
    wd <= d;
    aw <= 1'b1;
    w <= 1'b1;
    b <= 1'b1;
    do begin
      @(posedge clk);
      if (aw && awr) aw <= 1'b0;
      if (w && wr_) w <= 1'b0;
    end while (bv !== 1'b1);
    b <= 1'b0;
    @(posedge clk);
  endtask

  // Read cycle, expected response and data noted first
  task rreq(input logic [31:0] a, input logic [33:0] e);
    q.push_back(e);
    ara <= a;
    ar <= 1'b1;
    r <= 1'b1;
    do begin
      @(posedge clk);
      if (ar && arr) ar <= 1'b0;
    end while (rv !== 1'b1);
    r <= 1'b0;
    @(posedge clk);
  endtask

  // Output watcher takes the oldest note for every result seen
  always @(posedge clk) begin
    if (bv && b) check({br, 32'h0}, pop());
    if (rv && r) check({rr, rd}, pop());
    if (rel) check(rel_n, pop());
  end

  // Watchdog against a hang
  initial begin
    #(20000 * 5);
    failures++;
    results();
  end

  // Main sequence
  initial begin
    void'($urandom(37));
    init = 4'($urandom);
    keys = init;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    load <= 1'b0;
    @(posedge clk);
    rreq(en_a, {ok, 32'h0});
    rreq(32'hd0, {er, 32'h0});
    wreq(32'hd0, 32'hff, er);
    for (int k = 0; k < 5; k++) begin
      m = (k < 4) ? 32'h2 : 32'h0;
      wreq(en_a, (k < 4) ? 32'h10 << k : 32'h0, ok);
      wreq(ct_a, m, ok);
      rreq(ct_a, {ok, m});
      wreq(ct_a, m | 32'h1, ok);
      // Exit pin pulse inside the ignore window must not release
      ex <= (k < 4);
      repeat (3) @(posedge clk);
      ex <= 1'b0;
      repeat (20) @(posedge clk);
      check(34'(sa), 34'h1);
      if (k < 4) begin
        // A disabled key changing must not release
        flip <= 4'h1 << ((k + 1) % 4);
        keys = keys ^ (4'h1 << ((k + 1) % 4));
        @(posedge clk);
        flip <= 4'h0;
        repeat (8) @(posedge clk);
        q.push_back(rel_n);
        flip <= 4'h1 << k;
        keys = keys ^ (4'h1 << k);
      end else begin
        q.push_back(rel_n);
        ex <= 1'b1;
      end
      @(posedge clk);
      flip <= 4'h0;
      n = 0;
      while (rel !== 1'b1 && n < 10) begin
        @(posedge clk);
        n++;
      end
      check(34'(wb), 34'h1);
      n = 0;
      while (wb === 1'b1 && n < 40) begin
        n++;
        @(posedge clk);
      end
      check(34'(n), 34'(wu));
      check(34'(sa), 34'h0);
      rreq(st_a, {ok, 23'h0, ex, keys, 4'h0});
      ex <= 1'b0;
    end
    check(34'(q.size()), 34'h0);
    results();
  end
endmodule // key_wakeup_tb
